// ### logic/sae_regs.svh
// register offsets, field positions and reset values of the event aggregator
`ifndef SAE_REGS_SVH
`define SAE_REGS_SVH

// register byte offsets
`define SAE_SMI_STS1 8'h00
`define SAE_SMI_STATUS2 8'h04
`define SAE_SMI_STS3 8'h08
`define SAE_SMI_EN1 8'h0C
`define SAE_SMI_ENABLE2 8'h10
`define SAE_SMI_EN3 8'h14
`define SAE_EV_POL 8'h18
`define SAE_EV_EITHER 8'h1C
`define SAE_SMI_PIN_CTL 8'h20
`define SAE_WAKE_STS3 8'h24
`define SAE_WAKE_EN3 8'h28
`define SAE_WAKE_PIN 8'h2C
`define SAE_PB_STS3 8'h30
`define SAE_PB_EN3 8'h34
`define SAE_LIVE 8'h38

// second status register fields
`define SAE_STS2_IR 0
`define SAE_STS2_GWAKE 3
// second enable register fields
`define SAE_EN2_IR 0
`define SAE_EN2_GWAKE 3
`define SAE_EN2_TO_WAKE 5
`define SAE_EN2_IRQ2 6
`define SAE_EN2_PIN 7
// pin control fields
`define SAE_PCTL_ACT_LOW 1
`define SAE_PCTL_OPEN_DRAIN 7
`define SAE_PCTL_RESET 8'h82
// wake register fields
`define SAE_WK_MOUSE 0
`define SAE_WK_RING_A 1
`define SAE_WK_RING_B 2
`define SAE_WK_DEVIRQ 3
`define SAE_WK_LAST 4
`define SAE_WK_BITS 5
// wake pin register fields
`define SAE_WPIN_STS 0
`define SAE_WPIN_EN 1
// synchronised pins: 8 event pins then mouse, ring a, ring b, last state, low power
`define SAE_NEV 8
`define SAE_NPIN 13
`define SAE_PIN_MOUSE 8
`define SAE_PIN_RING_A 9
`define SAE_PIN_RING_B 10
`define SAE_PIN_LAST 11
`define SAE_PIN_LOWPWR 12

`endif

// ### logic/sae_pkg.sv
// types shared by the event aggregator
package sae_pkg;
	typedef logic [31:0] sae_word_type;
	typedef logic [7:0] sae_byte_type;
	typedef logic [7:0] sae_addr_type;
endpackage : sae_pkg

// ### logic/sae_event_aggregator.sv
// interrupt and wake event aggregator with an apb register file
//
// Notes on behaviour
// [RQ1] group interrupt is the OR of every status ANDed with its enable.
// [RQ2] group interrupt reaches its pin only while enable-two bit 7 is set.
// [RQ3] enable-two bit 6 also routes the group interrupt onto serial irq2.
// [RQ4] enable-two bit 5 feeds the group interrupt into the wake logic.
// [RQ5] interrupt pin polarity is chosen by the pin control polarity bit.
// [RQ6] pin control bit 7 selects open-drain or push-pull driving.
// [RQ7] after reset the interrupt pin is active low and open-drain.
// [RQ8] pin events set status on the edge picked by polarity; rising by default.
// [RQ9] either-edge mode sets the pin status on rising and falling edges.
// [RQ10] pin status bits clear only by writing one; zero leaves them.
// [RQ11] pin events interrupt through latched status ANDed with enable.
// [RQ12] peripheral status follows its source; writes of one do nothing.
// [RQ13] infrared status clears when software reads status register two.
// [RQ14] peripheral events are ANDed live with enables, without latching.
// [RQ15] status-two bit 3 shows group wake, write-one clear; enable-two bit 3 gates it.
// [RQ16] wake output asserts only while the system sits in S3 or lower.
// [RQ17] wake output is active low on the standby well.
// [RQ18] a separate path drives the power button output from chosen wake events.
// [RQ19] last-state event always enabled on button path, optional on pin path.
// [RQ20] mouse data edge raises pin-path and button-path events separately.
// [RQ21] wake status bits stay set until software writes one.
// [RQ22] pin status sets from status and enable; output needs pin enable too.
// [RQ23] device interrupt wake status and enable sit at bit 3 of wake regs three.
// [RQ24] group interrupt drops once no status and enable pair is set.
// [RQ25] software arms enables and clears stale status before enabling pins.
//
// Chosen here: the register offsets and register access over APB.
`include "sae_regs.svh"

module sae_event_aggregator (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire sae_pkg::sae_addr_type paddr,
	input wire sae_pkg::sae_word_type pwdata,
	output logic pready,
	output sae_pkg::sae_word_type prdata,
	output logic pslverr,
	// live peripheral interrupt levels, same clock
	input wire sae_pkg::sae_byte_type periph_irq,
	input wire logic infrared_irq,
	// asynchronous pins
	input wire sae_pkg::sae_byte_type event_pin,
	input wire logic mouse_data,
	input wire logic ring_indicator_a,
	input wire logic ring_indicator_b,
	input wire logic last_state_event,
	input wire logic low_power_state,
	// interrupt and wake outputs
	output logic group_sysmgmt_irq,
	output logic sysmgmt_irq_pin_out,
	output logic sysmgmt_irq_pin_oe,
	output logic serirq_irq2,
	output logic power_event_pin_n,
	output logic power_button_wake_n
);
	import sae_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [`SAE_NPIN-1:0] pin_raw;
	logic [`SAE_NPIN-1:0] sync_a;
	logic [`SAE_NPIN-1:0] sync_b;
	logic [`SAE_NPIN-1:0] sync_c;
	logic [`SAE_NPIN-1:0] pin_q;
	logic [`SAE_NPIN-1:0] pin_prev;
	logic [`SAE_NPIN-1:0] rise;
	logic [`SAE_NPIN-1:0] fall;
	sae_byte_type smi_sts3;
	sae_byte_type smi_en1;
	sae_byte_type sysmgmt_enable_reg_two;
	sae_byte_type smi_en3;
	sae_byte_type ev_pol;
	sae_byte_type either_edge_trigger;
	sae_byte_type pin_ctl;
	sae_byte_type next_sts3_set;
	logic infrared_irq_status;
	logic group_wake_status_bit;
	logic sts2_group_wake;
	logic group_wake_enable_bit;
	logic [`SAE_WK_BITS-1:0] wake_sts3;
	logic [`SAE_WK_BITS-1:0] wake_en3;
	logic [`SAE_WK_BITS-1:0] pb_sts3;
	logic [`SAE_WK_BITS-1:0] pb_en3;
	logic [`SAE_WK_BITS-1:0] pb_en_eff;
	logic [`SAE_WK_BITS-1:0] wake_set;
	logic next_group;
	logic next_level;
	logic group_wake;
	logic pb_any;
	logic low_power;
	logic acc_wr;
	logic setup_rd;
	logic wr_sts2;
	logic wr_sts3;
	logic wr_wsts;
	logic wr_pbsts;
	logic rd_sts2;
	logic addr_ok;
	sae_word_type next_rdata;

	// three-stage synchronisers; a new level counts once stages two and three agree
	assign pin_raw = {low_power_state, last_state_event, ring_indicator_b,
		ring_indicator_a, mouse_data, event_pin};
	genvar g;
	generate
		for (g = 0; g < `SAE_NPIN; g++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
					sync_c[g] <= 1'b0;
					pin_q[g] <= 1'b0;
					pin_prev[g] <= 1'b0;
				end else begin
					sync_a[g] <= pin_raw[g];
					sync_b[g] <= sync_a[g];
					sync_c[g] <= sync_b[g];
					if (sync_b[g] == sync_c[g]) begin
						pin_q[g] <= sync_c[g];
					end
					pin_prev[g] <= pin_q[g];
				end
			end
		end
	endgenerate
	assign rise = pin_q & ~pin_prev;
	assign fall = ~pin_q & pin_prev;
	assign low_power = pin_q[`SAE_PIN_LOWPWR];

	// apb strobes; writes land at the access edge, read side effects at the setup edge
	assign acc_wr = psel & penable & pready & pwrite;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign wr_sts2 = acc_wr & (paddr == `SAE_SMI_STATUS2);
	assign wr_sts3 = acc_wr & (paddr == `SAE_SMI_STS3);
	assign wr_wsts = acc_wr & (paddr == `SAE_WAKE_STS3);
	assign wr_pbsts = acc_wr & (paddr == `SAE_PB_STS3);
	assign rd_sts2 = setup_rd & (paddr == `SAE_SMI_STATUS2);

	// edge select per event pin: polarity picks the edge, either-edge takes both
	assign next_sts3_set = (either_edge_trigger
		& (rise[`SAE_NEV-1:0] | fall[`SAE_NEV-1:0])) // [RQ9]
		| (~either_edge_trigger & ~ev_pol & rise[`SAE_NEV-1:0]) // [RQ8]
		| (~either_edge_trigger & ev_pol & fall[`SAE_NEV-1:0]); // [RQ8]

	// latched pin status; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smi_sts3 <= 8'h00;
		end else begin
			smi_sts3 <= (smi_sts3 & ~(wr_sts3 ? pwdata[7:0] : 8'h00)) | next_sts3_set; // [RQ10]
		end
	end

	// infrared status is cleared by reading status two; a new event still wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			infrared_irq_status <= 1'b0;
		end else begin
			infrared_irq_status <= (infrared_irq_status & ~rd_sts2) | infrared_irq; // [RQ13]
		end
	end

	// read-write control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smi_en1 <= 8'h00;
			sysmgmt_enable_reg_two <= 8'h00;
			smi_en3 <= 8'h00;
			ev_pol <= 8'h00;
			either_edge_trigger <= 8'h00;
			pin_ctl <= `SAE_PCTL_RESET; // [RQ7]
			wake_en3 <= '0;
			pb_en3 <= '0;
			group_wake_enable_bit <= 1'b0;
		end else if (acc_wr) begin
			unique case (paddr)
				`SAE_SMI_EN1: smi_en1 <= pwdata[7:0];
				`SAE_SMI_ENABLE2: sysmgmt_enable_reg_two <= pwdata[7:0];
				`SAE_SMI_EN3: smi_en3 <= pwdata[7:0];
				`SAE_EV_POL: ev_pol <= pwdata[7:0];
				`SAE_EV_EITHER: either_edge_trigger <= pwdata[7:0];
				`SAE_SMI_PIN_CTL: pin_ctl <= pwdata[7:0];
				`SAE_WAKE_EN3: wake_en3 <= pwdata[`SAE_WK_BITS-1:0];
				`SAE_PB_EN3: pb_en3 <= pwdata[`SAE_WK_BITS-1:0];
				`SAE_WAKE_PIN: group_wake_enable_bit <= pwdata[`SAE_WPIN_EN];
				default: ;
			endcase
		end
	end

	// group interrupt: live peripheral levels plus latched status, each with its enable
	assign next_group = (|(periph_irq & smi_en1)) // [RQ14] [RQ12]
		| (infrared_irq_status & sysmgmt_enable_reg_two[`SAE_EN2_IR])
		| (sts2_group_wake & sysmgmt_enable_reg_two[`SAE_EN2_GWAKE]) // [RQ15]
		| (|(smi_sts3 & smi_en3)); // [RQ1] [RQ11]
	// pin level after gating and polarity; xor with the active-low bit
	assign next_level = (next_group & sysmgmt_enable_reg_two[`SAE_EN2_PIN]) // [RQ2]
		^ pin_ctl[`SAE_PCTL_ACT_LOW]; // [RQ5]

	// outputs are registered straight from the combined terms so no extra latch delays release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_sysmgmt_irq <= 1'b0;
			sysmgmt_irq_pin_out <= 1'b0;
			sysmgmt_irq_pin_oe <= 1'b0;
			serirq_irq2 <= 1'b0;
		end else begin
			group_sysmgmt_irq <= next_group; // [RQ24]
			serirq_irq2 <= next_group & sysmgmt_enable_reg_two[`SAE_EN2_IRQ2]; // [RQ3]
			// open drain only ever pulls low, so a high level means release
			if (pin_ctl[`SAE_PCTL_OPEN_DRAIN]) begin // [RQ6]
				sysmgmt_irq_pin_out <= 1'b0;
				sysmgmt_irq_pin_oe <= ~next_level;
			end else begin
				sysmgmt_irq_pin_out <= next_level;
				sysmgmt_irq_pin_oe <= 1'b1;
			end
		end
	end

	// wake events shared by both paths; mouse and ring pins idle high
	assign wake_set[`SAE_WK_MOUSE] = fall[`SAE_PIN_MOUSE]; // [RQ20]
	assign wake_set[`SAE_WK_RING_A] = fall[`SAE_PIN_RING_A];
	assign wake_set[`SAE_WK_RING_B] = fall[`SAE_PIN_RING_B];
	assign wake_set[`SAE_WK_DEVIRQ] = group_sysmgmt_irq & sysmgmt_enable_reg_two[`SAE_EN2_TO_WAKE]; // [RQ4] [RQ23]
	assign wake_set[`SAE_WK_LAST] = rise[`SAE_PIN_LAST];
	assign group_wake = |(wake_sts3 & wake_en3); // [RQ22] [RQ19]
	// last-state event cannot be masked on the button path
	assign pb_en_eff = pb_en3 | (`SAE_WK_BITS'(1) << `SAE_WK_LAST); // [RQ19]
	assign pb_any = |(pb_sts3 & pb_en_eff); // [RQ18]

	// sticky wake status, pin status and group wake status; sets win over clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_sts3 <= '0;
			pb_sts3 <= '0;
			group_wake_status_bit <= 1'b0;
			sts2_group_wake <= 1'b0;
		end else begin
			wake_sts3 <= (wake_sts3 & ~(wr_wsts ? pwdata[`SAE_WK_BITS-1:0] : '0))
				| wake_set; // [RQ21]
			pb_sts3 <= (pb_sts3 & ~(wr_pbsts ? pwdata[`SAE_WK_BITS-1:0] : '0))
				| wake_set; // [RQ20] [RQ21]
			group_wake_status_bit <= (group_wake_status_bit
				& ~(acc_wr & (paddr == `SAE_WAKE_PIN) & pwdata[`SAE_WPIN_STS]))
				| group_wake; // [RQ22]
			sts2_group_wake <= (sts2_group_wake & ~(wr_sts2 & pwdata[`SAE_STS2_GWAKE]))
				| group_wake; // [RQ15]
		end
	end

	// active-low wake outputs, only while asleep in S3 or below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_event_pin_n <= 1'b1;
			power_button_wake_n <= 1'b1;
		end else begin
			power_event_pin_n <= ~(group_wake_status_bit & group_wake_enable_bit
				& low_power); // [RQ16] [RQ17]
			power_button_wake_n <= ~(pb_any & low_power); // [RQ18]
		end
	end

	// read mux; unmapped addresses read zero and flag an error
	always_comb begin
		next_rdata = 32'h0000_0000;
		addr_ok = 1'b1;
		unique case (paddr)
			`SAE_SMI_STS1: next_rdata[7:0] = periph_irq; // [RQ12]
			`SAE_SMI_STATUS2: begin
				next_rdata[`SAE_STS2_IR] = infrared_irq_status;
				next_rdata[`SAE_STS2_GWAKE] = sts2_group_wake;
			end
			`SAE_SMI_STS3: next_rdata[7:0] = smi_sts3;
			`SAE_SMI_EN1: next_rdata[7:0] = smi_en1;
			`SAE_SMI_ENABLE2: next_rdata[7:0] = sysmgmt_enable_reg_two;
			`SAE_SMI_EN3: next_rdata[7:0] = smi_en3;
			`SAE_EV_POL: next_rdata[7:0] = ev_pol;
			`SAE_EV_EITHER: next_rdata[7:0] = either_edge_trigger;
			`SAE_SMI_PIN_CTL: next_rdata[7:0] = pin_ctl;
			`SAE_WAKE_STS3: next_rdata[`SAE_WK_BITS-1:0] = wake_sts3;
			`SAE_WAKE_EN3: next_rdata[`SAE_WK_BITS-1:0] = wake_en3;
			`SAE_WAKE_PIN: begin
				next_rdata[`SAE_WPIN_STS] = group_wake_status_bit;
				next_rdata[`SAE_WPIN_EN] = group_wake_enable_bit;
			end
			`SAE_PB_STS3: next_rdata[`SAE_WK_BITS-1:0] = pb_sts3;
			`SAE_PB_EN3: next_rdata[`SAE_WK_BITS-1:0] = pb_en_eff;
			`SAE_LIVE: next_rdata[3:0] = {~power_button_wake_n, ~power_event_pin_n,
				low_power, group_sysmgmt_irq};
			default: addr_ok = 1'b0;
		endcase
	end

	// apb answer: data captured at the setup edge, ready for exactly one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= ~addr_ok;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// helper copies for the checks below
	logic chk_act_low_q;
	logic chk_pin_active;
	// polarity as it stood when the pin level was launched; a polarity write would
	// otherwise make the idle level look active for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_act_low_q <= 1'b1; // pin control resets to active low
		end else begin
			chk_act_low_q <= pin_ctl[`SAE_PCTL_ACT_LOW];
		end
	end
	// level on the wire, a released pin floats high, then judged against polarity
	assign chk_pin_active = (sysmgmt_irq_pin_oe ? sysmgmt_irq_pin_out : 1'b1) ^ chk_act_low_q;

	a_pin_gate: assert property (chk_pin_active |-> $past(sysmgmt_enable_reg_two[`SAE_EN2_PIN])) // [RQ2]
		else $error("interrupt pin active with pin route disabled");
	a_irq2_route: assert property ($rose(serirq_irq2) |-> $past(sysmgmt_enable_reg_two[`SAE_EN2_IRQ2])) // [RQ3]
		else $error("irq2 raised without its route enable");
	a_devirq_wake: assert property (group_sysmgmt_irq && sysmgmt_enable_reg_two[`SAE_EN2_TO_WAKE] // [RQ4]
		|=> wake_sts3[`SAE_WK_DEVIRQ] && pb_sts3[`SAE_WK_DEVIRQ])
		else $error("device interrupt did not reach wake status");
	a_rise_default: assert property (rise[0] && !either_edge_trigger[0] && !ev_pol[0] // [RQ8]
		|=> smi_sts3[0])
		else $error("rising edge failed to set pin status");
	a_either_edge: assert property (fall[0] && either_edge_trigger[0] |=> smi_sts3[0]) // [RQ9]
		else $error("falling edge in either-edge mode was missed");
	a_sts3_sticky: assert property ($past(smi_sts3[0]) && !$past(wr_sts3) |-> smi_sts3[0]) // [RQ10]
		else $error("pin status dropped without a write");
	a_ir_readclr: assert property (rd_sts2 && !infrared_irq ##1 !infrared_irq // [RQ13]
		|-> !infrared_irq_status)
		else $error("infrared status survived a read");
	a_group_clear: assert property (!next_group |=> !group_sysmgmt_irq ##1 1'b1) // [RQ24]
		else $error("group interrupt held with no enabled source");
	a_wake_sleep: assert property (!power_event_pin_n |-> $past(low_power)) // [RQ16]
		else $error("wake output asserted outside low power");
	a_last_state_pb: assert property (pb_sts3[`SAE_WK_LAST] && low_power // [RQ19]
		|=> !power_button_wake_n)
		else $error("last-state event did not drive the button output");
	a_wake_sticky: assert property ($past(wake_sts3[`SAE_WK_MOUSE]) && !$past(wr_wsts) // [RQ21]
		|-> wake_sts3[`SAE_WK_MOUSE])
		else $error("wake status dropped without a write");
	a_reset_pin: assert property ($rose(presetn) |-> pin_ctl == `SAE_PCTL_RESET) // [RQ7]
		else $error("pin control not at reset value");
	a_od_low_only: assert property ($past(pin_ctl[`SAE_PCTL_OPEN_DRAIN]) // [RQ6]
		|-> !sysmgmt_irq_pin_out)
		else $error("open-drain pin drove a high level");
	a_button_sleep: assert property (!power_button_wake_n |-> $past(low_power)) // [RQ18]
		else $error("button output asserted outside low power");

	c_pin_asserted: cover property (chk_pin_active ##1 !chk_pin_active);
	c_wake_out: cover property ($fell(power_event_pin_n));
	c_button_out: cover property ($fell(power_button_wake_n));
	c_ir_read: cover property (rd_sts2 && infrared_irq_status);

endmodule : sae_event_aggregator

// ### verification/sae_chipset_model.sv
// chipset side model: resolves the open-drain interrupt wire and watches wake lines
module sae_chipset_model (
	// pin drive from the aggregator
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic power_event_pin_n,
	input wire logic power_button_wake_n,
	// resolved wire and what the chipset sees
	output logic sysmgmt_irq_pin,
	output logic wake_request,
	output logic button_request
);
	timeunit 1ns;
	timeprecision 1ps;
	// released wire floats to the board pull-up, never to the last driven level
	assign sysmgmt_irq_pin = pin_oe ? pin_out : 1'b1;
	// both wake lines are taken as active low requests
	assign wake_request = ~power_event_pin_n;
	assign button_request = ~power_button_wake_n;
endmodule : sae_chipset_model

// ### verification/tb.sv
// self-checking bench for the event aggregator
`include "sae_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sae_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, infrared_irq;
	logic mouse_data, ring_indicator_a, ring_indicator_b, last_state_event, low_power_state;
	logic group_sysmgmt_irq, pin_out, pin_oe, serirq_irq2, power_event_pin_n;
	logic power_button_wake_n, sysmgmt_irq_pin, err, wake_req, button_req;
	sae_addr_type paddr;
	sae_word_type pwdata, prdata, rdq;
	sae_byte_type periph_irq, event_pin;
	int failures, num_checks;
	sae_event_aggregator dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .periph_irq(periph_irq), .infrared_irq(infrared_irq),
		.event_pin(event_pin), .mouse_data(mouse_data), .ring_indicator_a(ring_indicator_a),
		.ring_indicator_b(ring_indicator_b), .last_state_event(last_state_event),
		.low_power_state(low_power_state), .group_sysmgmt_irq(group_sysmgmt_irq),
		.sysmgmt_irq_pin_out(pin_out), .sysmgmt_irq_pin_oe(pin_oe), .serirq_irq2(serirq_irq2),
		.power_event_pin_n(power_event_pin_n), .power_button_wake_n(power_button_wake_n));
	sae_chipset_model chipset (.pin_out(pin_out), .pin_oe(pin_oe),
		.power_event_pin_n(power_event_pin_n), .power_button_wake_n(power_button_wake_n),
		.sysmgmt_irq_pin(sysmgmt_irq_pin), .wake_request(wake_req),
		.button_request(button_req));
	// 250 MHz clock
	always #2 pclk = ~pclk;
	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_word(input sae_word_type g, input sae_word_type e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_bit
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle
	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input sae_addr_type a, input sae_word_type d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdq = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
	endtask : apb
	task automatic wr(input sae_addr_type a, input sae_word_type d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input sae_addr_type a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic t_reset();
		rd(`SAE_SMI_PIN_CTL);
		chk_word(rdq, 32'h00000082);
		chk_bit(sysmgmt_irq_pin, 1'b1);
		chk_bit(power_event_pin_n, 1'b1);
		rd(8'hFC);
		chk_bit(err, 1'b1);
		chk_word(rdq, 32'h0);
		// stale status from pin sync start-up is cleared before arming
		wr(`SAE_SMI_STS3, 32'hFF);
		wr(`SAE_WAKE_STS3, 32'h1F);
		wr(`SAE_PB_STS3, 32'h1F);
		$display("test reset done");
	endtask : t_reset
	task automatic t_periph();
		wr(`SAE_SMI_EN1, 32'h01);
		wr(`SAE_SMI_ENABLE2, 32'h80);
		periph_irq <= 8'h01;
		idle(3);
		chk_bit(group_sysmgmt_irq, 1'b1);
		chk_bit(sysmgmt_irq_pin, 1'b0);
		wr(`SAE_SMI_STS1, 32'hFF);
		rd(`SAE_SMI_STS1);
		chk_word(rdq, 32'h01);
		wr(`SAE_SMI_ENABLE2, 32'h40);
		idle(2);
		chk_bit(sysmgmt_irq_pin, 1'b1);
		chk_bit(serirq_irq2, 1'b1);
		wr(`SAE_SMI_ENABLE2, 32'hC0);
		wr(`SAE_SMI_PIN_CTL, 32'h00);
		idle(2);
		chk_bit(pin_oe & pin_out, 1'b1);
		wr(`SAE_SMI_PIN_CTL, 32'h02);
		idle(2);
		chk_bit(pin_oe | pin_out, 1'b1);
		chk_bit(sysmgmt_irq_pin, 1'b0);
		// open-drain active high: an asserted pin is released to the pull-up
		wr(`SAE_SMI_PIN_CTL, 32'h80);
		idle(2);
		chk_bit(pin_oe, 1'b0);
		chk_bit(sysmgmt_irq_pin, 1'b1);
		wr(`SAE_SMI_PIN_CTL, 32'h82);
		periph_irq <= 8'h00;
		idle(3);
		chk_bit(group_sysmgmt_irq, 1'b0);
		chk_bit(serirq_irq2, 1'b0);
		chk_bit(sysmgmt_irq_pin, 1'b1);
		$display("test periph done");
	endtask : t_periph
	task automatic t_gpio();
		wr(`SAE_SMI_EN1, 32'h00);
		wr(`SAE_SMI_EN3, 32'h01);
		event_pin <= 8'h01;
		idle(8);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h01);
		chk_bit(group_sysmgmt_irq, 1'b1);
		wr(`SAE_SMI_STS3, 32'h00);
		event_pin <= 8'h00;
		idle(8);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h01);
		wr(`SAE_SMI_STS3, 32'h01);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h00);
		chk_bit(group_sysmgmt_irq, 1'b0);
		wr(`SAE_EV_POL, 32'h01);
		event_pin <= 8'h01;
		idle(8);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h00);
		event_pin <= 8'h00;
		idle(8);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h01);
		wr(`SAE_EV_EITHER, 32'h02);
		event_pin <= 8'h02;
		idle(8);
		wr(`SAE_SMI_STS3, 32'hFF);
		event_pin <= 8'h00;
		idle(8);
		rd(`SAE_SMI_STS3);
		chk_word(rdq, 32'h02);
		wr(`SAE_SMI_STS3, 32'hFF);
		$display("test gpio done");
	endtask : t_gpio
	task automatic t_infrared();
		infrared_irq <= 1'b1;
		idle(1);
		infrared_irq <= 1'b0;
		idle(2);
		rd(`SAE_SMI_STATUS2);
		chk_word(rdq & 32'h1, 32'h1);
		rd(`SAE_SMI_STATUS2);
		chk_word(rdq & 32'h1, 32'h0);
		$display("test infrared done");
	endtask : t_infrared
	task automatic t_wake();
		wr(`SAE_SMI_EN1, 32'h01);
		wr(`SAE_SMI_ENABLE2, 32'h20);
		periph_irq <= 8'h01;
		idle(4);
		rd(`SAE_WAKE_STS3);
		chk_word(rdq & 32'h08, 32'h08);
		wr(`SAE_WAKE_EN3, 32'h08);
		wr(`SAE_WAKE_PIN, 32'h02);
		low_power_state <= 1'b1;
		idle(8);
		chk_bit(power_event_pin_n, 1'b0);
		chk_bit(wake_req, 1'b1);
		low_power_state <= 1'b0;
		periph_irq <= 8'h00;
		idle(8);
		chk_bit(power_event_pin_n, 1'b1);
		rd(`SAE_WAKE_STS3);
		chk_word(rdq & 32'h08, 32'h08);
		rd(`SAE_SMI_STATUS2);
		chk_word(rdq & 32'h08, 32'h08);
		wr(`SAE_SMI_EN1, 32'h00);
		wr(`SAE_SMI_ENABLE2, 32'h08);
		idle(2);
		chk_bit(group_sysmgmt_irq, 1'b1);
		wr(`SAE_WAKE_STS3, 32'h1F);
		wr(`SAE_WAKE_PIN, 32'h01);
		wr(`SAE_SMI_STATUS2, 32'h08);
		idle(2);
		chk_bit(group_sysmgmt_irq, 1'b0);
		mouse_data <= 1'b0;
		idle(8);
		rd(`SAE_WAKE_STS3);
		chk_word(rdq & 32'h01, 32'h01);
		rd(`SAE_PB_STS3);
		chk_word(rdq & 32'h01, 32'h01);
		mouse_data <= 1'b1;
		low_power_state <= 1'b1;
		last_state_event <= 1'b1;
		idle(8);
		chk_bit(power_button_wake_n, 1'b0);
		chk_bit(button_req, 1'b1);
		rd(`SAE_WAKE_STS3);
		chk_word(rdq & 32'h10, 32'h10);
		wr(`SAE_PB_STS3, 32'h1F);
		idle(3);
		chk_bit(power_button_wake_n, 1'b1);
		chk_bit(button_req, 1'b0);
		$display("test wake done");
	endtask : t_wake
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, infrared_irq, last_state_event, low_power_state} = 6'h00;
		{mouse_data, ring_indicator_a, ring_indicator_b} = 3'h7;
		paddr = 8'h00;
		pwdata = 32'h0;
		periph_irq = 8'h00;
		event_pin = 8'h00;
		failures = 0;
		num_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		idle(8);
		t_reset();
		t_periph();
		t_gpio();
		t_infrared();
		t_wake();
		report_and_stop();
	end
endmodule : tb
